// ---- core/rmc_regs.sv ----
// Radio mode control register bank behind an AXI4-Lite slave
// What this block does
// R1 - Strobe byte write of a defined code moves the radio to that state.
// R2 - Software writes only the six defined strobe codes.
// R3 - Strobe address reads live done, clock-out, two irq and frame-sync levels.
// R4 - Auto strength enable starts a strength measurement on each receive entry.
// R5 - Auto offset enable shifts the oscillator one IF on each receive entry.
// R6 - Carrier-gated filter discards packets arriving without carrier detect.
// R7 - Bit 4 of receive options reads the carrier detector output.
// R8 - Software keeps internal bits 3 and 2 of receive options at zero.
// R9 - Path select bit: zero direct bit stream, one buffered mode.
// R10 - Measure trigger starts a conversion and clears itself when done.
// R11 - Five calibration trigger bits start calibrations and clear when done.
// R12 - Calibration bit 5 enables buffer reverse operation.
// R13 - Write-only buffer end pointer, reset 0x3f.
// R14 - Pointer margin bits 7:6 reset 01, segment start bits 5:0 reset 0.
// R15 - Ten-bit sleep interval from low byte plus two upper bits.
// R16 - Nine-bit active interval from wake register and calibration bits 7:6.
// R17 - Two-bit divider selects divide by 8, 16, 32 or 64.
// R18 - System clock for the radio core should be 8 MHz; the bench clocks it at 100 MHz.
// R19 - Checksum select: zero 16-bit, one 24-bit, when low energy off.
// R20 - Bit 3 of clock register enables low-energy packet mode.
// R21 - Timer select zero active, one sleep; separate enable turns wake on.
// R22 - Slow oscillator source: zero internal, one external.
// R23 - Undefined strobe code leaves the state unchanged.
module rmc_regs (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [rmc_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [rmc_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Radio core status and completions
  input wire rmc_pkg::rmc_status_t i_status,
  input wire logic i_measure_done,
  input wire logic [4:0] i_cal_done,
  input wire logic i_packet_end,
  // Radio core control
  output rmc_pkg::rmc_state_t o_radio_state,
  output logic o_state_change,
  output logic o_measure_trigger,
  output logic o_measure_in_rx,
  output logic [4:0] o_cal_triggers,
  output logic o_auto_strength_start,
  output logic o_auto_lo_offset,
  output logic o_packet_accept,
  output logic o_packet_discard,
  output logic o_digital_clk_en,
  output rmc_pkg::rmc_cfg_t o_cfg
);
  import rmc_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  // Strobe code to state; valid flag is false for reserved codes
  function automatic logic code_valid(input logic [7:0] code);
    code_valid = (code == CODE_SLEEP) || (code == CODE_IDLE) || (code == CODE_STANDBY) ||
                 (code == CODE_SYNTH) || (code == CODE_TX) || (code == CODE_RX);
  endfunction

  function automatic rmc_state_t code_state(input logic [7:0] code);
    case (code)
      CODE_SLEEP: code_state = RMC_SLEEP;
      CODE_IDLE: code_state = RMC_IDLE;
      CODE_STANDBY: code_state = RMC_STANDBY;
      CODE_SYNTH: code_state = RMC_SYNTH;
      CODE_TX: code_state = RMC_TX;
      CODE_RX: code_state = RMC_RX;
      default: code_state = RMC_IDLE;
    endcase
  endfunction

  // Byte address to register index; misaligned or out-of-range addresses never match
  function automatic logic [11:0] addr_idx(input logic [ADDR_W-1:0] addr);
    addr_idx = (addr[1:0] == 2'b00 && addr[ADDR_W-1:14] == 2'b00) ? addr[13:2] : 12'hfff;
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] aw_idx_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  rmc_state_t state_r;
  rmc_state_t state_nxt;
  logic state_change_r;
  logic [7:0] rxo_r;
  logic [7:0] cal_r;
  logic [7:0] fifo_end_r;
  logic [7:0] fifo_margin_r;
  logic [7:0] sleep_low_r;
  logic [7:0] wake_mixed_r;
  logic [7:0] ccw_r;
  logic auto_strength_r;
  logic auto_lo_r;
  logic accept_r;
  logic discard_r;
  logic [5:0] div_cnt_r;

  // ************************************************************
  // Write channel
  // ************************************************************
  // Address and data are taken independently, then the write fires
  wire aw_take = i_awvalid && o_awready;
  wire w_take = i_wvalid && o_wready;
  wire [11:0] aw_idx_now = aw_held_r ? aw_idx_r : addr_idx(i_awaddr);
  wire [7:0] wdata_now = w_held_r ? wdata_r : i_wdata[7:0];
  wire wlane_now = w_held_r ? wlane_r : i_wstrb[0];
  wire wr_fire = (aw_held_r || aw_take) && (w_held_r || w_take) && !bvalid_r;
  wire wr_mapped = (aw_idx_now >= IDX_STATE_STROBE) && (aw_idx_now <= IDX_CLK_CRC_WAKE);
  wire wr_en = wr_fire && wr_mapped && wlane_now;
  wire wr_strobe = wr_en && (aw_idx_now == IDX_STATE_STROBE);
  wire wr_rxo = wr_en && (aw_idx_now == IDX_RX_OPTIONS);
  wire wr_cal = wr_en && (aw_idx_now == IDX_CAL_TRIGGERS);

  assign o_awready = !aw_held_r && !bvalid_r;
  assign o_wready = !w_held_r && !bvalid_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;

  // Hold the half that arrives first
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 12'h000;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
    end else begin
      aw_held_r <= !wr_fire && (aw_held_r || aw_take);
      w_held_r <= !wr_fire && (w_held_r || w_take);
      if (aw_take) aw_idx_r <= addr_idx(i_awaddr);
      if (w_take) wdata_r <= i_wdata[7:0];
      if (w_take) wlane_r <= i_wstrb[0];
    end
  end

  // Response one cycle after both halves are in
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // Radio state
  // ************************************************************
  // Reserved codes fall through and keep the present state
  assign state_nxt = (wr_strobe && code_valid(wdata_now)) ? code_state(wdata_now) // [R1]
                                                          : state_r; // [R23]
  wire enter_rx = (state_nxt == RMC_RX) && (state_r != RMC_RX);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_r <= RMC_IDLE;
      state_change_r <= 1'b0;
    end else begin
      state_r <= state_nxt; // [R1]
      state_change_r <= wr_strobe && code_valid(wdata_now);
    end
  end

  // Receive entry automation; a repeated receive strobe is not an entry
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      auto_strength_r <= 1'b0;
      auto_lo_r <= 1'b0;
    end else begin
      auto_strength_r <= enter_rx && rxo_r[RXO_AUTO_STRENGTH]; // [R4]
      auto_lo_r <= enter_rx && rxo_r[RXO_AUTO_LO]; // [R5]
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // Self-clearing triggers: a fresh write start beats a completion in the same cycle
  wire meas_nxt = wr_rxo ? wdata_now[RXO_MEASURE]
                         : (rxo_r[RXO_MEASURE] && !i_measure_done); // [R10]
  wire [4:0] cal_nxt = (cal_r[4:0] & ~i_cal_done) | (wr_cal ? wdata_now[4:0] : 5'h00); // [R11]

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rxo_r <= RST_RX_OPTIONS;
      cal_r <= RST_CAL_TRIGGERS;
    end else begin
      if (wr_rxo) rxo_r[7:1] <= wdata_now[7:1]; // [R9]
      rxo_r[RXO_MEASURE] <= meas_nxt;
      if (wr_cal) cal_r[7:5] <= wdata_now[7:5]; // [R12]
      cal_r[4:0] <= cal_nxt;
    end
  end

  // Plain configuration bytes
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      fifo_end_r <= RST_FIFO_END; // [R13]
      fifo_margin_r <= RST_FIFO_MARGIN; // [R14]
      sleep_low_r <= RST_SLEEP_LOW;
      wake_mixed_r <= RST_WAKE_MIXED;
      ccw_r <= RST_CLK_CRC_WAKE;
    end else if (wr_en) begin
      if (aw_idx_now == IDX_FIFO_END) fifo_end_r <= wdata_now; // [R13]
      if (aw_idx_now == IDX_FIFO_MARGIN) fifo_margin_r <= wdata_now; // [R14]
      if (aw_idx_now == IDX_SLEEP_LOW) sleep_low_r <= wdata_now; // [R15]
      if (aw_idx_now == IDX_WAKE_MIXED) wake_mixed_r <= wdata_now; // [R16]
      if (aw_idx_now == IDX_CLK_CRC_WAKE) ccw_r <= wdata_now; // [R17]
    end
  end

  // ************************************************************
  // Packet filter
  // ************************************************************
  // Carrier is sampled at the end-of-packet pulse itself
  wire gate_on = rxo_r[RXO_CARRIER];
  wire drop_pkt = i_packet_end && gate_on && !i_status.carrier_detect_out;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      accept_r <= 1'b0;
      discard_r <= 1'b0;
    end else begin
      accept_r <= i_packet_end && !drop_pkt;
      discard_r <= drop_pkt; // [R6]
    end
  end

  // ************************************************************
  // Digital clock divider
  // ************************************************************
  // Enable every 8 << select cycles; a select change restarts cleanly at wrap
  wire [5:0] div_last = 6'((6'd8 << ccw_r[7:6]) - 6'd1);
  wire div_wrap = (div_cnt_r >= div_last);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      div_cnt_r <= 6'h00;
    end else begin
      div_cnt_r <= div_wrap ? 6'h00 : 6'(div_cnt_r + 6'd1); // [R17]
    end
  end

  assign o_digital_clk_en = div_wrap;

  // ************************************************************
  // Read channel
  // ************************************************************
  // Write-only registers read zero; only unmapped addresses error
  wire [11:0] ar_idx = addr_idx(i_araddr);
  wire ar_take = i_arvalid && o_arready;
  wire ar_mapped = (ar_idx >= IDX_STATE_STROBE) && (ar_idx <= IDX_CLK_CRC_WAKE);
  wire [7:0] status_byte = {i_status.wait_until_done_signal, i_status.clock_out_pin_level,
                            i_status.first_irq_pin_level, i_status.second_irq_pin_level,
                            i_status.frame_sync_ok, 3'b000}; // [R3]
  wire [7:0] rxo_byte = {1'b0, rxo_r[6:5], i_status.carrier_detect_out, rxo_r[3:0]}; // [R7]
  wire [7:0] rd_byte = (ar_idx == IDX_STATE_STROBE) ? status_byte :
                       (ar_idx == IDX_RX_OPTIONS) ? rxo_byte : 8'h00;

  assign o_arready = !rvalid_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= ar_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // Outputs to the radio core
  // ************************************************************
  // Measurement kind follows the state: strength in receive, sensors otherwise
  assign o_radio_state = state_r;
  assign o_state_change = state_change_r;
  assign o_measure_trigger = rxo_r[RXO_MEASURE]; // [R10]
  assign o_measure_in_rx = (state_r == RMC_RX);
  assign o_cal_triggers = cal_r[4:0]; // [R11]
  assign o_auto_strength_start = auto_strength_r;
  assign o_auto_lo_offset = auto_lo_r;
  assign o_packet_accept = accept_r;
  assign o_packet_discard = discard_r;

  // Configuration bundle; internal bits are passed as written
  always_comb begin
    o_cfg.packet_path_select = rxo_r[RXO_PATH_SELECT]; // [R9]
    o_cfg.internal_bit_a = rxo_r[3];
    o_cfg.internal_bit_b = rxo_r[2];
    o_cfg.buffer_reverse_enable = cal_r[CAL_REVERSE]; // [R12]
    o_cfg.buffer_end_pointer = fifo_end_r;
    o_cfg.pointer_margin = fifo_margin_r[7:6]; // [R14]
    o_cfg.segment_start = fifo_margin_r[5:0];
    o_cfg.sleep_interval_timer = {wake_mixed_r[7:6], sleep_low_r}; // [R15]
    o_cfg.active_interval_timer = {1'b0, cal_r[7:6], wake_mixed_r[5:0]}; // [R16]
    o_cfg.selected_wake_interval = ccw_r[CCW_TIMER_SEL] ? {wake_mixed_r[7:6], sleep_low_r}
                                   : {2'b00, cal_r[7:6], wake_mixed_r[5:0]}; // [R21]
    o_cfg.timed_wake_enable = ccw_r[CCW_WAKE_EN]; // [R21]
    o_cfg.wake_timer_select = ccw_r[CCW_TIMER_SEL];
    o_cfg.slow_osc_source = ccw_r[CCW_SLOW_OSC]; // [R22]
    o_cfg.checksum_select = ccw_r[CCW_CHECKSUM] && !ccw_r[CCW_LOW_ENERGY]; // [R19]
    o_cfg.low_energy_mode_enable = ccw_r[CCW_LOW_ENERGY]; // [R20]
    o_cfg.digital_clock_divider = ccw_r[7:6];
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // Gap between divider enables, for checking the ratio
  logic [7:0] gap_r;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      gap_r <= 8'h01; // Reset acts as an enable, so the first gap is full
    end else begin
      gap_r <= o_digital_clk_en ? 8'h01 : 8'(gap_r + 8'd1);
    end
  end

  sequence s_rx_entered;
    (state_r != RMC_RX) ##1 (state_r == RMC_RX);
  endsequence

  strobe_takes_state_a: assert property ( // [R1]
    (wr_strobe && wdata_now == CODE_TX) |=> (state_r == RMC_TX) && o_state_change)
    else $error("valid strobe did not set state");
  strobe_reserved_a: assert property ( // [R23]
    (wr_strobe && !code_valid(wdata_now)) |=> $stable(state_r) && !o_state_change)
    else $error("reserved strobe changed state");
  status_read_a: assert property ( // [R3]
    (ar_take && ar_idx == IDX_STATE_STROBE) |=>
      o_rvalid && (o_rdata[7:3] == $past(status_byte[7:3])) && (o_rdata[2:0] == 3'b000))
    else $error("status read wrong");
  rx_strength_a: assert property ( // [R4]
    s_rx_entered |-> (o_auto_strength_start == $past(rxo_r[RXO_AUTO_STRENGTH])))
    else $error("auto strength pulse wrong on rx entry");
  rx_offset_a: assert property ( // [R5]
    s_rx_entered |-> (o_auto_lo_offset == $past(rxo_r[RXO_AUTO_LO])))
    else $error("auto offset pulse wrong on rx entry");
  carrier_discard_a: assert property ( // [R6]
    (i_packet_end && gate_on && !i_status.carrier_detect_out) |=>
      o_packet_discard && !o_packet_accept)
    else $error("packet without carrier not discarded");
  measure_clear_a: assert property ( // [R10]
    (o_measure_trigger && i_measure_done && !wr_rxo) |=> !o_measure_trigger)
    else $error("measure trigger did not clear");
  cal_clear_a: assert property ( // [R11]
    (o_cal_triggers[0] && i_cal_done[0] && !wr_cal) |=> !o_cal_triggers[0])
    else $error("calibration trigger did not clear");
  div_ratio_a: assert property ( // [R17]
    (o_digital_clk_en && $stable(ccw_r[7:6]) && gap_r > 8'd1) |->
      (gap_r == 8'(8'd8 << ccw_r[7:6])))
    else $error("divider period wrong");
  write_answer_a: assert property (
    wr_fire |=> o_bvalid)
    else $error("write response missing");

endmodule

// ---- core/rmc_pkg.sv ----
// Package for the radio mode control register bank: offsets, fields, reset values, types
package rmc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [11:0] IDX_STATE_STROBE = 12'h801;
  localparam logic [11:0] IDX_RX_OPTIONS = 12'h802;
  localparam logic [11:0] IDX_CAL_TRIGGERS = 12'h803;
  localparam logic [11:0] IDX_FIFO_END = 12'h804;
  localparam logic [11:0] IDX_FIFO_MARGIN = 12'h805;
  localparam logic [11:0] IDX_SLEEP_LOW = 12'h806;
  localparam logic [11:0] IDX_WAKE_MIXED = 12'h807;
  localparam logic [11:0] IDX_CLK_CRC_WAKE = 12'h808;
  localparam int ADDR_W = 16;

  // ************************************************************
  // Strobe codes and reset values
  // ************************************************************
  localparam logic [7:0] CODE_SLEEP = 8'h80;
  localparam logic [7:0] CODE_IDLE = 8'h90;
  localparam logic [7:0] CODE_STANDBY = 8'ha0;
  localparam logic [7:0] CODE_SYNTH = 8'hb0;
  localparam logic [7:0] CODE_TX = 8'hc0;
  localparam logic [7:0] CODE_RX = 8'hd0;
  localparam logic [7:0] RST_RX_OPTIONS = 8'h00;
  localparam logic [7:0] RST_CAL_TRIGGERS = 8'h00;
  localparam logic [7:0] RST_FIFO_END = 8'h3f;
  localparam logic [7:0] RST_FIFO_MARGIN = 8'h40;
  localparam logic [7:0] RST_SLEEP_LOW = 8'h00;
  localparam logic [7:0] RST_WAKE_MIXED = 8'h00;
  localparam logic [7:0] RST_CLK_CRC_WAKE = 8'h05;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int RXO_AUTO_STRENGTH = 6;
  localparam int RXO_AUTO_LO = 5;
  localparam int RXO_CARRIER = 4;
  localparam int RXO_PATH_SELECT = 1;
  localparam int RXO_MEASURE = 0;
  localparam int CAL_REVERSE = 5;
  localparam int CCW_CHECKSUM = 4;
  localparam int CCW_LOW_ENERGY = 3;
  localparam int CCW_SLOW_OSC = 2;
  localparam int CCW_TIMER_SEL = 1;
  localparam int CCW_WAKE_EN = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // Radio states, one-hot
  typedef enum logic [5:0] {
    RMC_SLEEP = 6'b000001,
    RMC_IDLE = 6'b000010,
    RMC_STANDBY = 6'b000100,
    RMC_SYNTH = 6'b001000,
    RMC_TX = 6'b010000,
    RMC_RX = 6'b100000
  } rmc_state_t;

  // Live status from the radio core
  typedef struct packed {
    logic wait_until_done_signal;
    logic clock_out_pin_level;
    logic first_irq_pin_level;
    logic second_irq_pin_level;
    logic frame_sync_ok;
    logic carrier_detect_out;
  } rmc_status_t;

  // Static configuration to the radio core
  typedef struct packed {
    logic packet_path_select;
    logic internal_bit_a;
    logic internal_bit_b;
    logic buffer_reverse_enable;
    logic [7:0] buffer_end_pointer;
    logic [1:0] pointer_margin;
    logic [5:0] segment_start;
    logic [9:0] sleep_interval_timer;
    logic [8:0] active_interval_timer;
    logic [9:0] selected_wake_interval;
    logic timed_wake_enable;
    logic wake_timer_select;
    logic slow_osc_source;
    logic checksum_select;
    logic low_energy_mode_enable;
    logic [1:0] digital_clock_divider;
  } rmc_cfg_t;

endpackage

// ---- testbench/rmc_radio_model.sv ----
// Behavioural radio core: answers triggers, passes bench status and packet ends
module rmc_radio_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // From the bank and the bench
  input wire logic i_meas,
  input wire logic [4:0] i_cal,
  input wire logic [5:0] i_stat,
  input wire logic i_pkt,
  // To the bank
  output rmc_pkg::rmc_status_t o_status,
  output logic o_meas_done,
  output logic [4:0] o_cal_done,
  output logic o_pkt_end
);
  timeunit 1ns;
  timeprecision 1ps;
  import rmc_pkg::*;
  logic [2:0] mcnt_r;
  logic [2:0] ccnt_r;
  // Levels pass straight through so the bench knows what a read must show
  assign o_status = i_stat;
  assign o_pkt_end = i_pkt;
  // Work time counted from when a trigger line rises; the five calibration bits share one count from the first
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mcnt_r <= 3'h0;
      ccnt_r <= 3'h0;
    end else begin
      mcnt_r <= i_meas ? 3'(mcnt_r + 3'h1) : 3'h0;
      ccnt_r <= (|i_cal) ? 3'(ccnt_r + 3'h1) : 3'h0;
    end
  end
  // Completions only answer a pending trigger
  assign o_meas_done = i_meas && (mcnt_r == 3'h4);
  assign o_cal_done = (ccnt_r == 3'h4) ? i_cal : 5'h00;
endmodule

// ---- testbench/radio_mode_control_regs_test.sv ----
// Self-checking bench for the radio mode control register bank
module radio_mode_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rmc_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, pkt = 0;
  logic [15:0] awa = 16'h0000, ara = 16'h0000;
  logic [31:0] wd = 32'h0, rdat;
  logic [3:0] ws = 4'h0;
  logic [5:0] stat = 6'h00;
  logic awr, wrd, bv, arr, rv, sc, mt, mir, asr, alo, pa, pd, ce, md, pe;
  logic [1:0] bresp, rresp;
  logic [4:0] ct, cd;
  logic [2:0] seen = 3'b000; // Pulses standing when a write answers
  rmc_state_t st;
  rmc_cfg_t cfg;
  rmc_status_t sts;
  int failures = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk; // Stands in for the radio system clock
  rmc_regs dut (.i_clk_sys(clk), .i_reset(rst), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_awprot(3'h0), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
    .i_wstrb(ws), .o_bvalid(bv), .i_bready(bre), .o_bresp(bresp), .i_arvalid(arv),
    .o_arready(arr), .i_araddr(ara), .i_arprot(3'h0), .o_rvalid(rv), .i_rready(rre),
    .o_rdata(rdat), .o_rresp(rresp), .i_status(sts), .i_measure_done(md),
    .i_cal_done(cd), .i_packet_end(pe), .o_radio_state(st), .o_state_change(sc),
    .o_measure_trigger(mt), .o_measure_in_rx(mir), .o_cal_triggers(ct),
    .o_auto_strength_start(asr), .o_auto_lo_offset(alo), .o_packet_accept(pa),
    .o_packet_discard(pd), .o_digital_clk_en(ce), .o_cfg(cfg));
  rmc_radio_model core (.i_clk_sys(clk), .i_reset(rst), .i_meas(mt), .i_cal(ct),
    .i_stat(stat), .i_pkt(pkt), .o_status(sts), .o_meas_done(md), .o_cal_done(cd),
    .o_pkt_end(pe));
  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  // ************************************************************
  // Bus tasks: readies sampled at the falling edge, stable until the rise
  // ************************************************************
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic a, w, b;
    b = 0;
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    awa <= {2'b00, idx, 2'b00};
    wd <= {24'h0, d};
    ws <= 4'h1;
    bre <= 1;
    while (!b) begin
      @(negedge clk);
      a = awv && awr;
      w = wv && wrd;
      b = bv && bre;
      if (b) seen = {sc, asr, alo};
      r = bresp;
      @(posedge clk);
      if (a) awv <= 0;
      if (w) wv <= 0;
    end
    bre <= 0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic a, b;
    b = 0;
    @(posedge clk);
    arv <= 1;
    ara <= {2'b00, idx, 2'b00};
    rre <= 1;
    while (!b) begin
      @(negedge clk);
      a = arv && arr;
      b = rv && rre;
      d = rdat;
      r = rresp;
      @(posedge clk);
      if (a) arv <= 0;
    end
    rre <= 0;
    @(negedge clk);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk("state", st, RMC_IDLE);
    chk("end ptr", cfg.buffer_end_pointer, 8'h3f);
    chk("margin", {cfg.pointer_margin, cfg.segment_start}, 8'h40);
    chk("wake en", cfg.timed_wake_enable, 1'b1);
    chk("slow osc", cfg.slow_osc_source, 1'b1);
    rd(IDX_FIFO_END, d, r);
    chk("wo read", d, 32'h0);
    chk("wo resp", r, RESP_OKAY);
    rd(12'h900, d, r);
    chk("unmapped", r, RESP_DECERR);
    $display("reset test done");
  endtask
  task automatic t_strobe();
    logic [7:0] code [6] = '{CODE_SLEEP, CODE_IDLE, CODE_STANDBY, CODE_SYNTH, CODE_TX, CODE_RX};
    rmc_state_t es [6] = '{RMC_SLEEP, RMC_IDLE, RMC_STANDBY, RMC_SYNTH, RMC_TX, RMC_RX};
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      wr(IDX_STATE_STROBE, code[i], r);
      chk("state", st, es[i]);
      chk("change", seen[2], 1'b1);
    end
    wr(IDX_STATE_STROBE, 8'h55, r);
    chk("kept", st, RMC_RX);
    chk("no change", {seen[2], r}, {1'b0, RESP_OKAY});
    $display("strobe test done");
  endtask
  task automatic t_status();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      stat <= i ? 6'h15 : 6'h2a;
      rd(IDX_STATE_STROBE, d, r);
      chk("status", d, {24'h0, stat[5:1], 3'b000});
      rd(IDX_RX_OPTIONS, d, r);
      chk("carrier", d[4], stat[0]);
    end
    $display("status test done");
  endtask
  task automatic t_auto();
    logic [1:0] r;
    for (int e = 0; e < 2; e++) begin
      wr(IDX_RX_OPTIONS, e ? 8'h00 : 8'h60, r);
      wr(IDX_STATE_STROBE, CODE_STANDBY, r);
      wr(IDX_STATE_STROBE, CODE_RX, r);
      chk("auto rssi", seen[1], e ? 1'b0 : 1'b1);
      chk("auto lo", seen[0], e ? 1'b0 : 1'b1);
      chk("in rx", mir, 1'b1);
    end
    $display("auto test done");
  endtask
  task automatic t_trig();
    logic [31:0] d;
    logic [1:0] r;
    wr(IDX_RX_OPTIONS, 8'h03, r);
    chk("measure", mt, 1'b1);
    chk("path", cfg.packet_path_select, 1'b1);
    chk("internal", {cfg.internal_bit_a, cfg.internal_bit_b}, 2'b00);
    repeat (8) @(negedge clk);
    chk("measure clr", mt, 1'b0);
    rd(IDX_RX_OPTIONS, d, r);
    chk("opts", d, {27'h0, stat[0], 4'h2});
    wr(IDX_CAL_TRIGGERS, 8'h3f, r);
    chk("cal", {cfg.buffer_reverse_enable, ct}, 6'h3f);
    repeat (8) @(negedge clk);
    chk("cal clr", ct, 5'h00);
    $display("trigger test done");
  endtask
  task automatic t_pkt();
    logic [1:0] r;
    wr(IDX_RX_OPTIONS, 8'h10, r);
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      stat <= {5'h00, c[0]};
      pkt <= 1;
      @(posedge clk);
      pkt <= 0;
      @(negedge clk);
      chk("filter", {pa, pd}, c ? 2'b10 : 2'b01);
    end
    $display("packet test done");
  endtask
  task automatic t_cfg();
    logic [1:0] r;
    int t;
    wr(IDX_FIFO_END, 8'ha5, r);
    wr(IDX_FIFO_MARGIN, 8'h8c, r);
    wr(IDX_SLEEP_LOW, 8'h34, r);
    wr(IDX_WAKE_MIXED, 8'hd5, r);
    wr(IDX_CAL_TRIGGERS, 8'h80, r);
    wr(IDX_CLK_CRC_WAKE, 8'hd3, r);
    chk("fifo", {cfg.buffer_end_pointer, cfg.pointer_margin, cfg.segment_start}, 16'ha58c);
    chk("sleep", cfg.sleep_interval_timer, 10'h334);
    chk("active", cfg.active_interval_timer, 9'h095);
    chk("sel", cfg.selected_wake_interval, 10'h334);
    chk("crc", {cfg.checksum_select, cfg.low_energy_mode_enable}, 2'b10);
    chk("osc", {cfg.digital_clock_divider, cfg.slow_osc_source, cfg.wake_timer_select},
      4'b1101);
    while (!ce) @(negedge clk);
    t = 1;
    @(negedge clk);
    while (!ce && t < 200) begin
      @(negedge clk);
      t++;
    end
    chk("divide", t, 64);
    wr(IDX_CLK_CRC_WAKE, 8'h18, r);
    chk("le", {cfg.checksum_select, cfg.low_energy_mode_enable}, 2'b01);
    chk("sel act", cfg.selected_wake_interval, 10'h095);
    $display("config test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    t_reset();
    t_strobe();
    t_status();
    t_auto();
    t_trig();
    t_pkt();
    t_cfg();
    end_sim();
  end
endmodule
